//--- hw/adp_post_proc.sv
// Function
// - after reset, raw code reaches the buses sixteen sample cycles later
// - enabled digital functions add pipeline stages, lengthening total latency
// - gain and offset functions act only while the digital enable is 1
// - gain settable 0 to 6 dB in 0.5 dB steps, shrinking full scale
// - gain resets to 0 dB, the widest input range
// - enabled offset loop estimates each channel's dc and subtracts it every sample
// - 4-bit time constant: 0000 is 1M cycles, doubling to 2G at 1011
// - hold field at 0 freezes the estimate, which keeps being applied
// - offset loop is off after reset, no correction applied
// - three mode pins decode normal, global down, channel A down, multiplexed
// - multiplexed mode interleaves both channels onto the channel B bus
// - global power-down by pins or bit turns both output buses off
// - data valid again about 100 us after leaving global power-down
// - channel standby per channel, valid again about 50 us after wake
// - low-power state when the sample rate falls under 1 MSPS
// - output coding twos complement or offset binary, by bit or pin
// - positive overdrive gives FFF offset binary or 7FF twos complement
// - negative overdrive gives 000 offset binary or 800 twos complement
// - channel A bus is off while multiplexed mode is active
// - each channel delivers a 12-bit word with an aligned strobe
`default_nettype none
module adp_post_proc #(
   parameter int unsigned PDN_WAKE_CYC = adp_pkg::PDN_WAKE_CYC_DEF, // wake after global down
   parameter int unsigned STBY_WAKE_CYC = adp_pkg::STBY_WAKE_CYC_DEF // wake after standby
) (
   input wire logic core_clk, // 125 MHz
   input wire logic rst_n, // async, active low
   input wire logic sampleValid, // converter core sample strobe
   input wire logic [adp_pkg::SAMPLE_W-1:0] rawA, // channel A raw code, offset binary
   input wire logic [adp_pkg::SAMPLE_W-1:0] rawB, // channel B raw code, offset binary
   input wire logic powerModePinFirst, // mode pin 1
   input wire logic powerModePinSecond, // mode pin 2
   input wire logic powerModePinThird, // mode pin 3
   input wire logic formatSelectPin, // 1 = twos complement
   input wire logic parallelConfigPin, // 1 = format taken from pin
   input wire logic awvalid, // axi write address
   output logic awready, // axi
   input wire logic [adp_pkg::AXI_AW-1:0] awaddr, // axi
   input wire logic [2:0] awprot, // axi, unused
   input wire logic wvalid, // axi write data
   output logic wready, // axi
   input wire logic [31:0] wdata, // axi
   input wire logic [3:0] wstrb, // axi
   output logic bvalid, // axi write response
   input wire logic bready, // axi
   output logic [1:0] bresp, // axi
   input wire logic arvalid, // axi read address
   output logic arready, // axi
   input wire logic [adp_pkg::AXI_AW-1:0] araddr, // axi
   input wire logic [2:0] arprot, // axi, unused
   output logic rvalid, // axi read data
   input wire logic rready, // axi
   output logic [31:0] rdata, // axi
   output logic [1:0] rresp, // axi
   output logic [adp_pkg::SAMPLE_W-1:0] channelAOutputBus, // channel A word
   output logic channelAOutputEn, // channel A bus driven
   output logic channelAStrobe, // new word on A
   output logic [adp_pkg::SAMPLE_W-1:0] channelBOutputBus, // channel B word
   output logic channelBOutputEn, // channel B bus driven
   output logic channelBStrobe, // new word on B
   output logic channelBCarriesA, // B bus holds a channel A word
   output logic channelAValid, // A data trustworthy
   output logic channelBValid, // B data trustworthy
   output logic lowPowerState // sample clock stopped
);
   import adp_pkg::*;

   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] sync3;
      logic [4:0] pins;
      adp_pmode_t mode;
      logic unsupported;
      logic awready;
      logic wready;
      logic awHeld;
      logic wHeld;
      logic [AXI_AW-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic digEn;
      logic fmtTwos;
      logic pdnBit;
      logic stbyA;
      logic stbyB;
      logic [3:0] gain;
      logic loopEn;
      logic hold;
      logic [3:0] tc;
      logic [7:0] idle;
      logic lowPower;
      logic pdnAct;
      logic [1:0] stbyAct;
      logic [15:0] pdnCnt;
      logic [1:0][15:0] stbyCnt;
      logic [1:0][ACC_W-1:0] acc;
      logic [1:0][13:0] s1;
      logic [1:0][11:0] s2;
      logic [1:0][LINE_LEN-1:0][11:0] line;
      logic [11:0] busA;
      logic [11:0] busB;
      logic oeA;
      logic oeB;
      logic strobeA;
      logic strobeB;
      logic tagB;
      logic muxPend;
      logic [11:0] muxWord;
      logic validA;
      logic validB;
   } adp_state_t;

   adp_state_t st;
   adp_state_t next_st;
   logic twos;
   logic [1:0][13:0] est;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [31:0] ctrlImg;
      logic [31:0] offImg;
      logic [31:0] img;
      logic [11:0] raw;
      logic [11:0] cen;
      logic [24:0] prod;
      logic [47:0] shifted;
      logic [5:0] sh;
      logic [13:0] corr;
      logic [14:0] diff;
      logic [11:0] lineIn;
      int tap;
      ctrlImg = '0;
      offImg = '0;
      img = '0;
      raw = '0;
      cen = '0;
      prod = '0;
      shifted = '0;
      sh = '0;
      corr = '0;
      diff = '0;
      lineIn = '0;
      tap = st.digEn ? DIG_TAP : RAW_TAP;
      next_st = st;
      est = '0;

      // pins: three flops, a change counts once the last two agree
      next_st.sync1 = {parallelConfigPin, formatSelectPin, powerModePinThird,
                       powerModePinSecond, powerModePinFirst};
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      if (st.sync2 == st.sync3) next_st.pins = st.sync3;
      twos = st.pins[4] ? st.pins[3] : st.fmtTwos;

      next_st.unsupported = 1'b0;
      unique case (st.pins[2:0])
         3'b000: next_st.mode = PM_NORMAL;
         3'b001: next_st.mode = PM_PDN;
         3'b101: next_st.mode = PM_STBYA;
         3'b111: next_st.mode = PM_MUX;
         default: begin
            next_st.mode = PM_NORMAL;
            next_st.unsupported = 1'b1;
         end
      endcase

      // ****************************************
      // power control
      // ****************************************
      next_st.pdnAct = (st.mode == PM_PDN) || st.pdnBit;
      next_st.stbyAct[0] = st.stbyA || (st.mode == PM_STBYA);
      next_st.stbyAct[1] = st.stbyB;
      if (st.pdnAct) next_st.pdnCnt = 16'(PDN_WAKE_CYC);
      else if (st.pdnCnt != 16'h0) next_st.pdnCnt = st.pdnCnt - 16'h1;
      for (int c = 0; c < 2; c++) begin
         if (st.stbyAct[c]) next_st.stbyCnt[c] = 16'(STBY_WAKE_CYC);
         else if (st.stbyCnt[c] != 16'h0) next_st.stbyCnt[c] = st.stbyCnt[c] - 16'h1;
      end
      // a missing sample strobe is how a stopped input clock shows here
      if (sampleValid) next_st.idle = 8'h0;
      else if (st.idle != CLKSTOP_CYC) next_st.idle = st.idle + 8'h1;
      next_st.lowPower = (next_st.idle == CLKSTOP_CYC);

      next_st.oeA = !st.pdnAct && !st.stbyAct[0] && (st.mode != PM_MUX);
      next_st.oeB = !st.pdnAct && (!st.stbyAct[1] || st.mode == PM_MUX);
      next_st.validA = next_st.oeA && !st.lowPower && st.pdnCnt == 16'h0
                       && st.stbyCnt[0] == 16'h0;
      next_st.validB = next_st.oeB && !st.lowPower && st.pdnCnt == 16'h0
                       && st.stbyCnt[1] == 16'h0
                       && (st.mode != PM_MUX || st.stbyCnt[0] == 16'h0);

      // ****************************************
      // data path
      // ****************************************
      for (int c = 0; c < 2; c++) begin
         raw = (c == 0) ? rawA : rawB;
         cen = raw ^ MID_CODE;
         prod = $signed({{13{cen[11]}}, cen}) * $signed({13'h0, adp_gain_factor(st.gain)});
         sh = TC_BASE_SHIFT + ((st.tc > TC_MAX) ? {2'h0, TC_MAX} : {2'h0, st.tc});
         shifted = $signed(st.acc[c]) >>> sh;
         est[c] = shifted[13:0];
         corr = (st.loopEn && st.digEn) ? est[c] : 14'h0;
         diff = $signed({st.s1[c][13], st.s1[c]}) - $signed({corr[13], corr});
         lineIn = st.digEn ? st.s2[c] : cen;
         // cleared even between samples, so a disabled loop never keeps a stale estimate
         if (!(st.loopEn && st.digEn)) next_st.acc[c] = '0;
         if (sampleValid) begin
            next_st.s1[c] = prod[23:10];
            next_st.s2[c] = adp_sat12(diff);
            next_st.line[c] = {st.line[c][LINE_LEN-2:0], lineIn};
            if (st.loopEn && st.digEn && st.hold)
               next_st.acc[c] = st.acc[c] + {{34{st.s1[c][13]}}, st.s1[c]}
                                - {{34{est[c][13]}}, est[c]};
         end
      end

      // ****************************************
      // output buses
      // ****************************************
      next_st.strobeA = 1'b0;
      next_st.strobeB = 1'b0;
      if (sampleValid) begin
         next_st.busA = adp_fmt(st.line[0][tap], twos);
         next_st.strobeA = 1'b1;
         next_st.strobeB = 1'b1;
         if (st.mode == PM_MUX) begin
            // B follows one cycle later; needs samples at least two cycles apart
            next_st.busB = adp_fmt(st.line[0][tap], twos);
            next_st.tagB = 1'b1;
            next_st.muxPend = 1'b1;
            next_st.muxWord = adp_fmt(st.line[1][tap], twos);
         end else begin
            next_st.busB = adp_fmt(st.line[1][tap], twos);
            next_st.tagB = 1'b0;
            next_st.muxPend = 1'b0;
         end
      end else if (st.muxPend) begin
         next_st.busB = st.muxWord;
         next_st.tagB = 1'b0;
         next_st.strobeB = 1'b1;
         next_st.muxPend = 1'b0;
      end

      // ****************************************
      // register bus
      // ****************************************
      ctrlImg[CTRL_DIG_EN_BIT] = st.digEn;
      ctrlImg[CTRL_FMT_BIT] = st.fmtTwos;
      ctrlImg[CTRL_PDN_BIT] = st.pdnBit;
      ctrlImg[CTRL_STBYA_BIT] = st.stbyA;
      ctrlImg[CTRL_STBYB_BIT] = st.stbyB;
      ctrlImg[CTRL_GAIN_LSB +: 4] = st.gain;
      offImg[OFF_EN_BIT] = st.loopEn;
      offImg[OFF_HOLD_BIT] = st.hold;
      offImg[OFF_TC_LSB +: 4] = st.tc;
      if (awvalid && st.awready) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && st.wready) begin
         next_st.wHeld = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      if (st.bvalid && bready) next_st.bvalid = 1'b0;
      if (st.awHeld && st.wHeld && !st.bvalid) begin
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         if (st.awAddr == REG_CTRL) begin
            img = adp_wmerge(ctrlImg, st.wData, st.wStrb);
            next_st.digEn = img[CTRL_DIG_EN_BIT];
            next_st.fmtTwos = img[CTRL_FMT_BIT];
            next_st.pdnBit = img[CTRL_PDN_BIT];
            next_st.stbyA = img[CTRL_STBYA_BIT];
            next_st.stbyB = img[CTRL_STBYB_BIT];
            next_st.gain = (img[CTRL_GAIN_LSB +: 4] > GAIN_MAX) ? GAIN_MAX
                           : img[CTRL_GAIN_LSB +: 4];
         end else if (st.awAddr == REG_OFFCFG) begin
            img = adp_wmerge(offImg, st.wData, st.wStrb);
            next_st.loopEn = img[OFF_EN_BIT];
            next_st.hold = img[OFF_HOLD_BIT];
            next_st.tc = img[OFF_TC_LSB +: 4];
         end else if (st.awAddr != REG_STATUS && st.awAddr != REG_EST) begin
            next_st.bresp = RESP_SLVERR;
         end
      end
      next_st.awready = !next_st.awHeld && !next_st.bvalid;
      next_st.wready = !next_st.wHeld && !next_st.bvalid;

      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
      if (arvalid && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         next_st.rdata = '0;
         unique case (araddr)
            REG_CTRL: next_st.rdata = ctrlImg;
            REG_OFFCFG: next_st.rdata = offImg;
            REG_STATUS: next_st.rdata = {20'h0, st.mode, 1'b0, st.unsupported, st.pdnAct,
                                         st.lowPower, st.stbyAct, st.validB, st.validA};
            REG_EST: next_st.rdata = {est[1][13], est[1][13], est[1],
                                      est[0][13], est[0][13], est[0]};
            default: next_st.rresp = RESP_SLVERR;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.mode <= PM_NORMAL;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.digEn <= CTRL_RST[CTRL_DIG_EN_BIT];
         st.gain <= CTRL_RST[CTRL_GAIN_LSB +: 4];
         st.loopEn <= OFFCFG_RST[OFF_EN_BIT];
         st.hold <= OFFCFG_RST[OFF_HOLD_BIT];
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign channelAOutputBus = st.busA;
   assign channelAOutputEn = st.oeA;
   assign channelAStrobe = st.strobeA;
   assign channelBOutputBus = st.busB;
   assign channelBOutputEn = st.oeB;
   assign channelBStrobe = st.strobeB;
   assign channelBCarriesA = st.tagB;
   assign channelAValid = st.validA;
   assign channelBValid = st.validB;
   assign lowPowerState = st.lowPower;

   // ****************************************
   // checks
   // ****************************************
   logic [5:0] rawRun;
   logic [5:0] digRun;
   logic prevTwos;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rawRun <= 6'h0;
         digRun <= 6'h0;
         prevTwos <= 1'b0;
      end else begin
         prevTwos <= twos;
         if (sampleValid && !st.digEn && twos == prevTwos)
            rawRun <= (rawRun == 6'h3f) ? rawRun : rawRun + 6'h1;
         else
            rawRun <= 6'h0;
         if (sampleValid && st.digEn && st.gain == 4'h0 && !st.loopEn && twos == prevTwos)
            digRun <= (digRun == 6'h3f) ? digRun : digRun + 6'h1;
         else
            digRun <= 6'h0;
      end
   end

   default clocking adp_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_raw_latency: assert property (rawRun >= 6'd17 |->
      st.busA == adp_fmt($past(rawA, 17) ^ MID_CODE, twos))
      else $error("raw path latency is not 16 samples");
   a_dig_latency: assert property (digRun >= 6'd21 |->
      st.busA == adp_fmt($past(rawA, 21) ^ MID_CODE, twos))
      else $error("digital path latency is not 20 samples");
   a_feat_gate: assert property (!st.digEn ##1 !st.digEn |-> st.acc == '0)
      else $error("offset estimate moved while digital functions off");
   a_gain_range: assert property (st.gain <= GAIN_MAX)
      else $error("gain setting above 6 dB");
   a_gain_default: assert property (!$past(rst_n) |-> st.gain == 4'h0)
      else $error("gain not 0 dB after reset");
   a_hold_freeze: assert property (!st.hold ##1 !st.hold |-> $stable(st.acc))
      else $error("offset estimate updated while held");
   a_loop_default: assert property (!$past(rst_n) |-> !st.loopEn && st.acc == '0)
      else $error("offset loop active after reset");
   a_pin_decode: assert property (st.pins[2:0] == 3'b111 |=> st.mode == PM_MUX)
      else $error("mode pins all high did not select multiplexed mode");
   a_pdn_hiz: assert property (st.pdnAct |=> !st.oeA && !st.oeB)
      else $error("bus driven during global power-down");
   a_pdn_wake: assert property (st.pdnAct || st.pdnCnt != 16'h0 |=> !st.validA)
      else $error("channel A valid before wake-up time elapsed");
   a_clk_stop: assert property (!sampleValid [*8] ##1 st.idle == CLKSTOP_CYC && !sampleValid
      |=> st.lowPower) else $error("low-power state not entered");
   a_neg_clamp: assert property (sampleValid && st.digEn && $signed(st.s1[0]) < -14'sd2048
      && !st.loopEn |=> st.s2[0] == NEG_FULL)
      else $error("negative overdrive not clamped");
   a_mux_hiz: assert property (st.mode == PM_MUX |=> !st.oeA)
      else $error("channel A bus driven in multiplexed mode");

   c_mux_word: cover property (st.muxPend ##1 st.strobeB && !st.tagB);
   c_pdn_wake: cover property ($fell(st.pdnAct) ##[1:1000] st.pdnCnt == 16'h1);
   c_low_power: cover property ($rose(st.lowPower));
   c_dig_on: cover property (digRun == 6'd21);

endmodule // adp_post_proc
`default_nettype wire

//--- hw/adp_pkg.sv
`default_nettype none
package adp_pkg;

   // ****************************************
   // sample path
   // ****************************************
   localparam int SAMPLE_W = 12;
   localparam int RAW_LAT = 16;
   localparam int DIG_EXTRA = 4;
   localparam int LINE_LEN = RAW_LAT + DIG_EXTRA - 2;
   localparam int RAW_TAP = RAW_LAT - 1;
   localparam int DIG_TAP = RAW_LAT + DIG_EXTRA - 3;
   localparam logic [11:0] MID_CODE = 12'h800;
   localparam logic [11:0] POS_FULL = 12'h7ff;
   localparam logic [11:0] NEG_FULL = 12'h800;
   localparam logic [3:0] GAIN_MAX = 4'hc;
   localparam logic [3:0] TC_MAX = 4'hb;
   localparam logic [5:0] TC_BASE_SHIFT = 6'h14;
   localparam int ACC_W = 48;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int PDN_WAKE_NS = 100000;
   localparam int STBY_WAKE_NS = 50000;
   localparam int CLKSTOP_NS = 1000;
   localparam int PDN_WAKE_CYC_DEF = (PDN_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STBY_WAKE_CYC_DEF = (STBY_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CLKSTOP_CYC = 8'(CLKSTOP_NS / CLK_NS);

   // ****************************************
   // register map
   // ****************************************
   localparam int AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OFFCFG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_EST = 8'h0c;
   localparam int CTRL_DIG_EN_BIT = 0;
   localparam int CTRL_FMT_BIT = 1;
   localparam int CTRL_PDN_BIT = 2;
   localparam int CTRL_STBYA_BIT = 3;
   localparam int CTRL_STBYB_BIT = 4;
   localparam int CTRL_GAIN_LSB = 8;
   localparam int OFF_EN_BIT = 0;
   localparam int OFF_HOLD_BIT = 1;
   localparam int OFF_TC_LSB = 4;
   localparam int EST_B_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OFFCFG_RST = 32'h0000_0002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      PM_NORMAL = 4'h1,
      PM_PDN = 4'h2,
      PM_STBYA = 4'h4,
      PM_MUX = 4'h8
   } adp_pmode_t;

   // half-decibel steps as Q.10 factors
   function automatic logic [11:0] adp_gain_factor(input logic [3:0] g);
      unique case (g)
         4'h0: return 12'h400;
         4'h1: return 12'h43c;
         4'h2: return 12'h47d;
         4'h3: return 12'h4c1;
         4'h4: return 12'h509;
         4'h5: return 12'h556;
         4'h6: return 12'h5a6;
         4'h7: return 12'h5fc;
         4'h8: return 12'h657;
         4'h9: return 12'h6b7;
         4'ha: return 12'h71d;
         4'hb: return 12'h789;
         default: return 12'h7fb;
      endcase
   endfunction

   function automatic logic [11:0] adp_sat12(input logic [14:0] v);
      if (!v[14] && v[13:11] != 3'h0) return POS_FULL;
      if (v[14] && v[13:11] != 3'h7) return NEG_FULL;
      return v[11:0];
   endfunction

   function automatic logic [11:0] adp_fmt(input logic [11:0] c, input logic twos);
      return twos ? c : c ^ MID_CODE;
   endfunction

   function automatic logic [31:0] adp_wmerge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

endpackage
`default_nettype wire

//--- verification/adp_capture_model.sv
`default_nettype none
module adp_capture_model (
   input wire logic core_clk, // clock
   input wire logic [11:0] busA, // a pins
   input wire logic enA, // a driven
   input wire logic [11:0] busB, // b pins
   input wire logic enB, // b driven
   output logic [11:0] seenA, // a level
   output logic [11:0] seenB // b level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] lastA = 12'h0;
   logic [11:0] lastB = 12'h0;
   // released pins toggle, so stale data matches only on every other cycle
   always @(posedge core_clk) begin
      lastA <= seenA;
      lastB <= seenB;
   end
   assign seenA = enA ? busA : ~lastA;
   assign seenB = enB ? busB : ~lastB;
endmodule // adp_capture_model
`default_nettype wire

//--- verification/test_adp_post_proc.sv
`default_nettype none
module test_adp_post_proc;
   timeunit 1ns;
   timeprecision 1ns;
   import adp_pkg::*;
   logic core_clk = 0, rst_n = 0, sampleValid = 0, awvalid = 0, wvalid = 0;
   logic bready = 0, arvalid = 0, rready = 0, streamOn = 0, dig, fmt, sat, mux = 0;
   logic fsp = 0, pcp = 0;
   logic awready, wready, bvalid, arready, rvalid, enA, enB, stbA, stbB, carA, valA, valB, lowP;
   logic [2:0] pins = 3'h0;
   logic [11:0] rawA = 12'h0, rawB = 12'h0, busA, busB, seenA, seenB, va, vb;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [23:0] x, sq[$];
   logic [33:0] rq[$];
   int num_errors = 0, checked = 0, lat, cnt, n;
   always #4 core_clk = ~core_clk;
   adp_post_proc #(.PDN_WAKE_CYC(20), .STBY_WAKE_CYC(10)) dut_u (.core_clk, .rst_n,
      .sampleValid, .rawA, .rawB, .powerModePinFirst(pins[0]), .powerModePinSecond(pins[1]),
      .powerModePinThird(pins[2]), .formatSelectPin(fsp), .parallelConfigPin(pcp),
      .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf),
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
      .rdata, .rresp, .channelAOutputBus(busA), .channelAOutputEn(enA), .channelAStrobe(stbA),
      .channelBOutputBus(busB), .channelBOutputEn(enB), .channelBStrobe(stbB),
      .channelBCarriesA(carA), .channelAValid(valA), .channelBValid(valB), .lowPowerState(lowP));
   adp_capture_model cap_u (.core_clk, .busA, .enA, .busB, .enB, .seenA, .seenB);
   task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tmo(int lim);
      if (n >= lim) begin
         num_errors++;
         $display("ERROR wait expected %0d seen %0d", lim, n);
         finish_test();
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      tmo(50);
      chk("bresp", RESP_OKAY, bresp);
      @(posedge core_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [33:0] e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      rq.push_back(e);
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      tmo(50);
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      if (rvalid && rready && rq.size() > 0) chk("rdata", rq.pop_front(), {rresp, rdata});
   end
   // saturated codes follow the sign of the corrected value
   function automatic logic [11:0] ex(logic [11:0] v);
      return (sat ? {12{v[11]}} : v) ^ {fmt, 11'h0};
   endfunction
   always @(posedge core_clk) begin
      sampleValid <= streamOn && !(mux && sampleValid);
      if (streamOn && !(mux && sampleValid)) begin
         va = mux ? 12'h5a5 : 12'($urandom);
         vb = mux ? 12'h3c3 : 12'($urandom);
         if (sat) va[10:8] = {3{va[11]}};
         if (sat) vb[10:8] = {3{vb[11]}};
         rawA <= va;
         rawB <= vb;
         sq.push_back({ex(va), ex(vb)});
      end
   end
   always @(negedge core_clk) begin
      if (streamOn && !mux && stbA === 1'h1) begin
         cnt++;
         if (cnt > lat) begin
            x = sq.pop_front();
            chk("busA", x[23:12], seenA);
            chk("busB", {x[11:0], 1'h1}, {seenB, stbB});
         end
      end
   end
   initial begin
      void'($urandom(59701));
      for (int t = 0; t < 6; t++) begin
         rst_n <= 1'h0;
         repeat (5) @(posedge core_clk);
         rst_n <= 1'h1;
         @(posedge core_clk);
         sq.delete();
         cnt = 0;
         dig = t inside {2, 3};
         fmt = t inside {1, 3, 4};
         pcp <= t == 4;
         fsp <= t == 4;
         sat = t == 3;
         lat = dig ? 20 : 16;
         if (t == 0) begin
            rd(REG_CTRL, {2'h0, CTRL_RST});
            rd(REG_OFFCFG, {2'h0, OFFCFG_RST});
            rd(8'h10, {RESP_SLVERR, 32'h0});
            wr(REG_OFFCFG, 32'hc1);
            rd(REG_OFFCFG, {2'h0, 32'hc1});
         end
         wr(REG_CTRL, {20'h0, (t > 2) ? 4'hc : 4'h0, 6'h0, fmt && t != 4, dig});
         mux = t == 5;
         streamOn <= 1'h1;
         repeat (300) @(posedge core_clk);
         if (mux) begin
            wr(REG_CTRL, 32'h4);
            repeat (5) @(posedge core_clk);
            chk("pdnBit", 2'h0, {enA, enB});
            wr(REG_CTRL, 32'h0);
            for (int k = 0; k < 4; k++) begin
               pins <= 3'(12'hf4b >> (9 - 3 * k));
               repeat (60) @(posedge core_clk);
               chk("oe", 2'(8'h53 >> (6 - 2 * k)), {enA, enB});
            end
            pins <= 3'h7;
            for (n = 0; n < 100 && !(stbB === 1'h1 && carA === 1'h1); n++) @(negedge core_clk);
            tmo(100);
            chk("muxA", 12'h5a5, seenB);
            @(negedge core_clk);
            chk("muxB", {12'h3c3, 1'h0}, {seenB, carA});
            @(posedge core_clk);
            pins <= 3'h0;
            repeat (60) @(posedge core_clk);
            pins <= 3'h1;
            repeat (30) @(posedge core_clk);
            pins <= 3'h0;
            repeat (10) @(posedge core_clk);
            chk("early", 1'h0, valA);
            repeat (40) @(posedge core_clk);
            chk("woken", 5'h1e, {enA, enB, valA, valB, lowP});
         end
         streamOn <= 1'h0;
         for (n = 0; n < 300 && lowP !== 1'h1; n++) @(posedge core_clk);
         tmo(300);
         $display("test %0d done", t);
      end
      finish_test();
   end
endmodule // test_adp_post_proc
`default_nettype wire
